// File: inc/ov_response_pkg.sv
package ov_response_pkg;
   // ------------------------------------------------------------------
   // Register command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h56;
   localparam logic [7:0] CMD_OV_WARN_THRESHOLD = 8'h57;
   localparam logic [7:0] CMD_UV_WARN_THRESHOLD = 8'h58;

   // ------------------------------------------------------------------
   // Field positions of the fault action register
   // ------------------------------------------------------------------
   localparam int RESP_MSB = 7;
   localparam int RESP_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;

   // ------------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_DELAYED = 2'h1;
   localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
   localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // ------------------------------------------------------------------
   // Reset values and widths
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_OV_FAULT_ACTION = 8'h80;
   localparam logic [15:0] RST_OV_WARN_THRESHOLD = 16'hffff;
   localparam logic [15:0] RST_UV_WARN_THRESHOLD = 16'h0000;
   localparam logic [23:0] RST_COUNT = 24'h000000;
   localparam int CNT_W = 24;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_DELAY,
      ST_RETRY_WAIT,
      ST_LATCHED,
      ST_OFF
   } fault_state_type;
endpackage

// File: hw/input_overvoltage_fault_response.sv
`timescale 1ns/100ps
module input_overvoltage_fault_response
   import ov_response_pkg::*;
(
   input wire logic clk_i, // 200 MHz clock
   input wire logic nrst_i, // Asynchronous reset, active low
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic [7:0] reg_cmd_i, // Command code
   input wire logic [15:0] reg_wdata_i, // Write data
   output logic [15:0] reg_rdata_o, // Read data, one cycle after strobe
   input wire logic ov_fault_i, // Input overvoltage fault comparator level
   input wire logic [15:0] vin_i, // Measured input voltage, linear code
   input wire logic [15:0] time_unit_cycles_i, // Clock cycles per delay unit
   input wire logic ratio_enable_i, // Ratio regulation option enabled
   input wire logic output_on_cmd_i, // Combined control pin and operation on
   input wire logic other_shutdown_i, // Another fault forces shutdown
   input wire logic clear_faults_i, // Clear-faults command pulse
   input wire logic status_clear_i, // Individual status bit clear pulse
   output logic output_enable_o, // Power stage enable
   output logic fault_latched_o, // Latched off awaiting clear
   output logic retrying_o, // Waiting between restart attempts
   output logic ov_fault_flag_o, // Sticky fault status flag
   output logic ov_warn_flag_o, // Sticky overvoltage warning flag
   output logic uv_warn_flag_o, // Sticky undervoltage warning flag
   output logic ratio_active_o, // Ratio threshold in use
   output logic [15:0] ratio_threshold_o // Ratio regulation threshold
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [CNT_W-1:0] delay_cycles(input logic [2:0] field,
                                                     input logic [15:0] unit);
      logic [CNT_W-1:0] wide;
      wide = {8'h00, unit} << field;
      delay_cycles = (wide == RST_COUNT) ? RST_COUNT : wide - 24'h000001;
   endfunction

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [7:0] fault_action;
   logic [15:0] ov_warn_threshold;
   logic [15:0] uv_warn_threshold;
   logic [7:0] next_fault_action;
   logic [15:0] next_ov_warn_threshold;
   logic [15:0] next_uv_warn_threshold;
   logic [15:0] next_reg_rdata;
   logic [1:0] resp;
   logic [2:0] retry;
   logic [2:0] delay;

   assign resp = fault_action[RESP_MSB:RESP_LSB];
   assign retry = fault_action[RETRY_MSB:RETRY_LSB];
   assign delay = fault_action[DELAY_MSB:DELAY_LSB];

   always_comb begin
      next_fault_action = fault_action;
      next_ov_warn_threshold = ov_warn_threshold;
      next_uv_warn_threshold = uv_warn_threshold;
      next_reg_rdata = reg_rdata_o;
      if (reg_wr_i) begin
         if (reg_cmd_i == CMD_OV_FAULT_ACTION) begin
            next_fault_action = reg_wdata_i[7:0];
         end else if (reg_cmd_i == CMD_OV_WARN_THRESHOLD) begin
            next_ov_warn_threshold = reg_wdata_i;
         end else if (reg_cmd_i == CMD_UV_WARN_THRESHOLD) begin
            next_uv_warn_threshold = reg_wdata_i;
         end
      end
      if (reg_rd_i) begin
         if (reg_cmd_i == CMD_OV_FAULT_ACTION) begin
            next_reg_rdata = {8'h00, fault_action};
         end else if (reg_cmd_i == CMD_OV_WARN_THRESHOLD) begin
            next_reg_rdata = ov_warn_threshold;
         end else if (reg_cmd_i == CMD_UV_WARN_THRESHOLD) begin
            next_reg_rdata = uv_warn_threshold;
         end else begin
            next_reg_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_action <= RST_OV_FAULT_ACTION;
         ov_warn_threshold <= RST_OV_WARN_THRESHOLD;
         uv_warn_threshold <= RST_UV_WARN_THRESHOLD;
         reg_rdata_o <= 16'h0000;
      end else begin
         fault_action <= next_fault_action;
         ov_warn_threshold <= next_ov_warn_threshold;
         uv_warn_threshold <= next_uv_warn_threshold;
         reg_rdata_o <= next_reg_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Fault response sequencer
   // ------------------------------------------------------------------
   fault_state_type state;
   fault_state_type next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [2:0] attempts;
   logic [2:0] next_attempts;
   logic [CNT_W-1:0] delay_load;
   logic clear_req;

   assign delay_load = delay_cycles(delay, time_unit_cycles_i);
   assign clear_req = clear_faults_i | status_clear_i;

   always_comb begin
      next_state = state;
      next_cnt = (cnt == RST_COUNT) ? RST_COUNT : cnt - 24'h000001;
      next_attempts = attempts;
      case (state)
         ST_RUN: begin
            if (ov_fault_i) begin
               if (resp == RESP_DELAYED) begin
                  next_state = ST_DELAY;
                  next_cnt = delay_load;
               end else if (resp == RESP_DISABLE_RETRY) begin
                  if (retry == RETRY_NONE) begin
                     next_state = ST_LATCHED;
                  end else begin
                     next_state = ST_RETRY_WAIT;
                     next_cnt = delay_load;
                     next_attempts = retry;
                  end
               end else if (resp == RESP_LATCH_OFF) begin
                  next_state = ST_LATCHED;
               end
            end
         end
         ST_DELAY: begin
            if (cnt == RST_COUNT) begin
               if (!ov_fault_i) begin
                  next_state = ST_RUN;
               end else if (retry == RETRY_NONE) begin
                  next_state = ST_LATCHED;
               end else begin
                  next_state = ST_RETRY_WAIT;
                  next_cnt = delay_load;
                  next_attempts = retry;
               end
            end
         end
         ST_RETRY_WAIT: begin
            if (cnt == RST_COUNT) begin
               // An attempt succeeds when the fault has gone by its start.
               if (!ov_fault_i) begin
                  next_state = ST_RUN;
               end else if (retry == RETRY_FOREVER) begin
                  next_cnt = delay_load;
               end else if (attempts <= 3'h1) begin
                  next_state = ST_LATCHED;
               end else begin
                  next_attempts = attempts - 3'h1;
                  next_cnt = delay_load;
               end
            end
         end
         ST_LATCHED: begin
            if (clear_req) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            if (output_on_cmd_i && !other_shutdown_i) begin
               next_state = ST_RUN;
            end
         end
      endcase
      // Commanded off or an outside shutdown ends any retry or latch.
      if (!output_on_cmd_i || other_shutdown_i) begin
         next_state = ST_OFF;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_OFF;
         cnt <= RST_COUNT;
         attempts <= RETRY_NONE;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         attempts <= next_attempts;
      end
   end

   // Enable is decoded from state so a disable takes effect next edge.
   assign output_enable_o = (state == ST_RUN) || (state == ST_DELAY);
   assign fault_latched_o = (state == ST_LATCHED);
   assign retrying_o = (state == ST_RETRY_WAIT);

   // ------------------------------------------------------------------
   // Status flags and ratio threshold
   // ------------------------------------------------------------------
   logic next_ov_fault_flag;
   logic next_ov_warn_flag;
   logic next_uv_warn_flag;
   logic next_ratio_active;
   logic [15:0] next_ratio_threshold;

   // The set term wins over a clear arriving in the same cycle.
   always_comb begin
      next_ov_fault_flag = (ov_fault_flag_o & ~clear_req) | ov_fault_i;
      next_ov_warn_flag = (ov_warn_flag_o & ~clear_faults_i) |
                          (vin_i > ov_warn_threshold);
      next_uv_warn_flag = (uv_warn_flag_o & ~clear_faults_i) |
                          (vin_i < uv_warn_threshold);
      next_ratio_active = ratio_enable_i;
      next_ratio_threshold = ratio_enable_i ? uv_warn_threshold : 16'h0000;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ov_fault_flag_o <= 1'b0;
         ov_warn_flag_o <= 1'b0;
         uv_warn_flag_o <= 1'b0;
         ratio_active_o <= 1'b0;
         ratio_threshold_o <= 16'h0000;
      end else begin
         ov_fault_flag_o <= next_ov_fault_flag;
         ov_warn_flag_o <= next_ov_warn_flag;
         uv_warn_flag_o <= next_uv_warn_flag;
         ratio_active_o <= next_ratio_active;
         ratio_threshold_o <= next_ratio_threshold;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   logic cmd_on;
   assign cmd_on = output_on_cmd_i && !other_shutdown_i;

   property p_ignore;
      (state == ST_RUN) && ov_fault_i && (resp == RESP_IGNORE) && cmd_on
         |=> output_enable_o;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored fault disabled output");

   property p_delay_runs;
      (state == ST_RUN) && ov_fault_i && (resp == RESP_DELAYED) && cmd_on
         ##1 (cmd_on && cnt > 24'h000001) |=> output_enable_o;
   endproperty
   a_delay_runs: assert property (p_delay_runs) else $error("delay mode stopped early");

   property p_disable_now;
      (state == ST_RUN) && ov_fault_i && (resp == RESP_DISABLE_RETRY) |=> !output_enable_o;
   endproperty
   a_disable_now: assert property (p_disable_now) else $error("output not disabled");

   property p_latch_holds;
      (state == ST_LATCHED) && !clear_req && cmd_on |=> fault_latched_o && !output_enable_o;
   endproperty
   a_latch_holds: assert property (p_latch_holds) else $error("latch released unasked");

   property p_off_on_clears;
      fault_latched_o && !output_on_cmd_i |=> (state == ST_OFF) ##1 cmd_on |=> output_enable_o;
   endproperty
   a_off_on_clears: assert property (p_off_on_clears) else $error("off-on did not clear");

   property p_no_retry;
      (state == ST_RUN) && ov_fault_i && (resp == RESP_DISABLE_RETRY) &&
         (retry == RETRY_NONE) && cmd_on |=> fault_latched_o;
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("retry 000 restarted");

   property p_retry_exhaust;
      retrying_o && (cnt == RST_COUNT) && ov_fault_i && (attempts == 3'h1) &&
         (retry != RETRY_FOREVER) && cmd_on |=> fault_latched_o;
   endproperty
   a_retry_exhaust: assert property (p_retry_exhaust) else $error("no latch after retries");

   property p_spacing;
      !retrying_o ##1 retrying_o |-> cnt == $past(delay_load);
   endproperty
   a_spacing: assert property (p_spacing) else $error("retry spacing wrong");

   property p_forever;
      retrying_o && (cnt == RST_COUNT) && ov_fault_i && (retry == RETRY_FOREVER) && cmd_on
         |=> retrying_o && !fault_latched_o;
   endproperty
   a_forever: assert property (p_forever) else $error("endless retry stopped");

   property p_ratio;
      ##1 ratio_active_o == $past(ratio_enable_i) &&
         (ratio_active_o || ratio_threshold_o == 16'h0000);
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio threshold misapplied");

   property p_warn_keeps_output;
      (vin_i > ov_warn_threshold) && !ov_fault_i && (state == ST_RUN) && cmd_on
         |=> ov_warn_flag_o && output_enable_o;
   endproperty
   a_warn_keeps_output: assert property (p_warn_keeps_output) else $error("warning misbehaved");

   c_latch: cover property ((resp == RESP_LATCH_OFF) && ov_fault_i ##1 fault_latched_o);
   c_retry_ok: cover property (retrying_o ##1 output_enable_o);
   c_exhaust: cover property (retrying_o ##1 fault_latched_o);
   c_delay_ok: cover property ((state == ST_DELAY) ##1 (state == ST_RUN));

endmodule

// File: testbench/ov_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module ov_host_model (
   input wire logic clk_i, // Clock
   output logic wr_o, // Write strobe
   output logic rd_o, // Read strobe
   output logic [7:0] cmd_o, // Command code
   output logic [15:0] wdata_o, // Write data
   input wire logic [15:0] rdata_i // Read data
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      cmd_o = 8'h00;
      wdata_o = 16'h0000;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge clk_i);
      cmd_o = c;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      // Idle data is inverted so a stale word is never mistaken for a write.
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(negedge clk_i);
      cmd_o = c;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask
endmodule

// File: testbench/input_overvoltage_fault_response_tb.sv
`timescale 1ns/100ps
module input_overvoltage_fault_response_tb;
   import ov_response_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, flt = 1'b0, ren = 1'b0, on = 1'b1;
   logic oth = 1'b0, cfc = 1'b0, sclr = 1'b0, en, lat, rty, ff, ow, uw, ra;
   logic wr, rd;
   logic [7:0] cmd;
   logic [15:0] wd, rdat, rthr, r, vin = 16'h4000, tu = 16'h0001;
   logic [15:0] mdl [0:2];
   int mismatches = 0, check_count = 0, cyc = 0, n, d, t, dd, nn, k;
   ov_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .cmd_o(cmd),
      .wdata_o(wd), .rdata_i(rdat));
   input_overvoltage_fault_response uut (.clk_i(clk), .nrst_i(nrst),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_cmd_i(cmd), .reg_wdata_i(wd),
      .reg_rdata_o(rdat), .ov_fault_i(flt), .vin_i(vin), .time_unit_cycles_i(tu),
      .ratio_enable_i(ren), .output_on_cmd_i(on), .other_shutdown_i(oth),
      .clear_faults_i(cfc), .status_clear_i(sclr), .output_enable_o(en),
      .fault_latched_o(lat), .retrying_o(rty), .ov_fault_flag_o(ff),
      .ov_warn_flag_o(ow), .uv_warn_flag_o(uw), .ratio_active_o(ra),
      .ratio_threshold_o(rthr));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   // A zero time unit collapses the whole delay to a single cycle.
   function automatic int dcyc(input int u, input int f);
      return (u == 0) ? 1 : (u << f);
   endfunction
   function automatic logic sig(input int s);
      case (s)
         0: return en;
         1: return lat;
         default: return rty;
      endcase
   endfunction
   task automatic cnt(input int s, input logic v, output int c);
      c = 0;
      while (sig(s) !== v && c < 2000) begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic setact(input logic [7:0] a, input int u);
      host.wr(CMD_OV_FAULT_ACTION, {8'h00, a});
      mdl[0] = {8'h00, a};
      tu = u[15:0];
   endtask
   task automatic clr(input int m);
      @(negedge clk);
      case (m)
         0: sclr = 1'b1;
         1: cfc = 1'b1;
         2: on = 1'b0;
         default: nrst = 1'b0;
      endcase
      @(negedge clk);
      {sclr, cfc, on, nrst} = 4'h3;
      mdl[0] = (m == 3) ? {8'h00, RST_OV_FAULT_ACTION} : mdl[0];
      // A clear pulse frees the latch on its own edge; off-on and reset pass through off.
      cnt(0, 1'b1, n);
      chk_cnt(n, (m < 2) ? 0 : 1, (m < 2) ? 0 : 1);
      chk_val(ff, (m == 2) ? 1'b1 : 1'b0);
   endtask
   initial begin
      mdl[0] = {8'h00, RST_OV_FAULT_ACTION};
      mdl[1] = RST_OV_WARN_THRESHOLD;
      mdl[2] = RST_UV_WARN_THRESHOLD;
      void'($urandom(32'h78f6));
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      host.wr(8'h00, 16'h00ff);
      for (k = 0; k < 4; k++) begin
         host.rd(8'h56 + k[7:0], r);
         chk_val(r, (k < 3) ? mdl[k] : 16'h0000);
      end
      setact(8'h00, 1);
      flt = 1'b1;
      repeat (50) @(negedge clk);
      chk_val(en, 1'b1);
      flt = 1'b0;
      for (k = 0; k < 4; k++) begin
         setact(8'hc0, 1);
         flt = 1'b1;
         cnt(0, 1'b0, n);
         chk_cnt(n, 1, 2);
         flt = 1'b0;
         repeat (20) @(negedge clk);
         chk_val({lat, en}, 2'h2);
         clr(k);
      end
      host.rd(CMD_OV_FAULT_ACTION, r);
      chk_val(r, mdl[0]);
      for (nn = 0; nn < 7; nn++) begin
         dd = $urandom_range(2, 0);
         t = $urandom_range(3, 0);
         d = dcyc(t, dd);
         setact({2'h2, nn[2:0], dd[2:0]}, t);
         flt = 1'b1;
         cnt(0, 1'b0, n);
         chk_cnt(n, 1, 2);
         cnt(1, 1'b1, n);
         chk_cnt(n, nn * d, nn * d);
         flt = 1'b0;
         clr(0);
      end
      setact({2'h2, 3'h3, 3'h1}, 2);
      flt = 1'b1;
      cnt(0, 1'b0, n);
      flt = 1'b0;
      cnt(0, 1'b1, n);
      chk_cnt(n, 1, 6);
      chk_val(lat, 1'b0);
      setact(8'hb8, 1);
      flt = 1'b1;
      repeat (200) @(negedge clk);
      chk_val({lat, en}, 2'h0);
      on = 1'b0;
      repeat (2) @(negedge clk);
      flt = 1'b0;
      repeat (5) @(negedge clk);
      chk_val({rty, en}, 2'h0);
      on = 1'b1;
      cnt(0, 1'b1, n);
      chk_cnt(n, 1, 3);
      oth = 1'b1;
      repeat (2) @(negedge clk);
      chk_val(en, 1'b0);
      oth = 1'b0;
      cnt(0, 1'b1, n);
      setact({2'h1, 3'h0, 3'h2}, 1);
      flt = 1'b1;
      cnt(0, 1'b0, n);
      chk_cnt(n, 4, 6);
      cnt(1, 1'b1, n);
      chk_cnt(n, 0, 2);
      flt = 1'b0;
      clr(1);
      flt = 1'b1;
      repeat (2) @(negedge clk);
      flt = 1'b0;
      repeat (8) @(negedge clk);
      chk_val(en, 1'b1);
      mdl[1] = 16'h6000 + 16'($urandom_range(8191, 0));
      mdl[2] = 16'h1000 + 16'($urandom_range(8191, 0));
      for (k = 1; k < 3; k++) begin
         host.wr(8'h56 + k[7:0], mdl[k]);
         host.rd(8'h56 + k[7:0], r);
         chk_val(r, mdl[k]);
      end
      vin = mdl[1] + 16'h0001;
      repeat (3) @(negedge clk);
      vin = 16'h4000;
      repeat (3) @(negedge clk);
      chk_val({ow, uw, en}, 3'h5);
      vin = mdl[2] - 16'h0001;
      repeat (3) @(negedge clk);
      chk_val({ow, uw, en}, 3'h7);
      vin = 16'h4000;
      clr(1);
      chk_val({ow, uw}, 2'h0);
      chk_val(rthr, 16'h0000);
      chk_val(ra, 1'b0);
      ren = 1'b1;
      repeat (3) @(negedge clk);
      chk_val(rthr, mdl[2]);
      chk_val(ra, 1'b1);
      tally_and_finish();
   end
endmodule
